/* File: hdl/dcl_pkg.sv */
package dcl_pkg;
  // field positions within configuration word zero
  localparam int DCL_FLASH_SLEEP_BIT = 10;
  localparam int DCL_ECC_LSB = 8;
  localparam int DCL_ISA_BIT = 6;
  localparam int DCL_TRACE_BIT = 5;
  localparam int DCL_CHAN_LSB = 3;
  localparam int DCL_SCAN_BIT = 2;
  localparam int DCL_DBG_LSB = 0;
  // position of the copies inside the run-time configuration register
  localparam int DCL_RT_SCAN_BIT = 3;
  localparam int DCL_RT_ECC_LSB = 4;

  // register byte offsets
  localparam logic [11:0] DCL_OFF_CFG0 = 12'h000;
  localparam logic [11:0] DCL_OFF_RTCFG = 12'h004;
  localparam logic [11:0] DCL_OFF_STAT = 12'h008;
  localparam logic [11:0] DCL_OFF_ADC0 = 12'h010;
  localparam int DCL_ADC_WORDS = 8;
  localparam logic [7:0] DCL_ADC_PRESENT = 8'h9F;

  localparam logic [1:0] DCL_ECC_OFF_RW = 2'h3;
  localparam logic [1:0] DCL_ECC_OFF_LK = 2'h2;
  localparam logic [1:0] DCL_ECC_DYN = 2'h1;
  localparam logic [1:0] DCL_ECC_FULL = 2'h0;
  localparam logic [1:0] DCL_ISA_32 = 2'h2;
  localparam logic [1:0] DCL_ISA_16 = 2'h3;
  localparam logic [1:0] DCL_CHAN_ONE = 2'h3;
  localparam logic [1:0] DCL_CHAN_TWO = 2'h2;
  localparam logic [31:0] DCL_RST_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    DCL_ST_RESET = 3'b001,
    DCL_ST_LOAD = 3'b010,
    DCL_ST_RUN = 3'b100
  } dcl_state_e;

  typedef struct packed {
    logic flash_sleep_power_down;
    logic [1:0] ecc_control_runtime;
    logic single_word_write_off;
    logic exception_isa_flag;
    logic [1:0] core_isa;
    logic trace_feature_enable;
    logic debug_pair_one;
    logic debug_pair_two;
    logic scan_port_enable;
    logic debugger_enable;
  } dcl_ctrl_s;
endpackage : dcl_pkg

/* File: hdl/dcl_apb_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module dcl_apb_slave
  import dcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  output logic pready,
  output logic pslverr,
  output logic acc_wr,
  output logic acc_rd
);
  // zero-wait slave: every access finishes in its first access cycle
  assign pready = psel & penable;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  assign pslverr = 1'b0;
endmodule : dcl_apb_slave
`default_nettype wire

/* File: hdl/dcl_loader.sv */
// What this block does
// - flash sleep bit set powers flash down in sleep; clear keeps it on
// - each reset copies the ecc field into the run-time ecc control
// - ecc codes: 11 off writable, 10 off locked, 01 dynamic, 00 full
// - boot isa 1 gives flag 0 isa 10; 0 gives flag 1 isa 11
// - trace bit enables cpu trace features
// - channel 11 routes debug to pair one, 10 to pair two
// - scan enable bit loads the run-time scan enable copy
// - debugger off when upper bit set; field reads 11 under protection
// - read-only calibration words for indices 0 to 4 and 7
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dcl_loader
  import dcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] nv_cfg_word,
  input wire logic [255:0] nv_adc_words,
  input wire logic code_protect,
  input wire logic sleep_mode,
  output logic flash_power_down,
  output dcl_ctrl_s ctrl,
  output logic load_done
);
  logic acc_wr;
  logic acc_rd;
  dcl_state_e state_ff;
  logic [31:0] cfg_ff;
  logic [1:0] ecc_rt_ff;
  logic scan_rt_ff;
  logic [31:0] adc_ff [DCL_ADC_WORDS];
  logic [31:0] nxt_prdata;
  logic ecc_wr_ok;
  logic [1:0] dbg_view;
  logic [2:0] adc_idx;
  logic [11:0] adc_off;
  logic adc_hit;

  dcl_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .pslverr(pslverr),
    .acc_wr(acc_wr),
    .acc_rd(acc_rd)
  );

  // one load cycle after reset release, then run until next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= DCL_ST_RESET;
    end else begin
      unique case (state_ff)
        DCL_ST_RESET: state_ff <= DCL_ST_LOAD;
        DCL_ST_LOAD: state_ff <= DCL_ST_RUN;
        DCL_ST_RUN: state_ff <= DCL_ST_RUN;
        default: state_ff <= DCL_ST_RESET;
      endcase
    end
  end

  assign load_done = (state_ff == DCL_ST_RUN);

  // capture word zero once per reset; held afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= DCL_RST_WORD;
    end else if (state_ff == DCL_ST_LOAD) begin
      cfg_ff <= nv_cfg_word;
    end
  end

  // calibration words captured with the config word
  generate
    for (genvar g = 0; g < DCL_ADC_WORDS; g++) begin : g_adc
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          adc_ff[g] <= DCL_RST_WORD;
        end else if (state_ff == DCL_ST_LOAD && DCL_ADC_PRESENT[g]) begin
          adc_ff[g] <= nv_adc_words[g*32 +: 32];
        end
      end
    end
  endgenerate

  // run-time ecc copy is writable only under code 11
  assign ecc_wr_ok = load_done && (cfg_ff[DCL_ECC_LSB +: 2] == DCL_ECC_OFF_RW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_rt_ff <= DCL_ECC_FULL;
    end else if (state_ff == DCL_ST_LOAD) begin
      ecc_rt_ff <= nv_cfg_word[DCL_ECC_LSB +: 2];
    end else if (acc_wr && paddr == DCL_OFF_RTCFG && ecc_wr_ok) begin
      ecc_rt_ff <= pwdata[DCL_RT_ECC_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_rt_ff <= 1'b0;
    end else if (state_ff == DCL_ST_LOAD) begin
      scan_rt_ff <= nv_cfg_word[DCL_SCAN_BIT];
    end
  end

  // debugger field forced to 11 under code protection
  assign dbg_view = code_protect ? 2'h3 : cfg_ff[DCL_DBG_LSB +: 2];

  always_comb begin
    ctrl = '0;
    if (load_done) begin
      ctrl.flash_sleep_power_down = cfg_ff[DCL_FLASH_SLEEP_BIT];
      ctrl.ecc_control_runtime = ecc_rt_ff;
      ctrl.single_word_write_off = (ecc_rt_ff == DCL_ECC_FULL);
      ctrl.exception_isa_flag = ~cfg_ff[DCL_ISA_BIT];
      ctrl.core_isa = cfg_ff[DCL_ISA_BIT] ? DCL_ISA_32 : DCL_ISA_16;
      ctrl.trace_feature_enable = cfg_ff[DCL_TRACE_BIT];
      ctrl.debug_pair_one =
        (cfg_ff[DCL_CHAN_LSB +: 2] == DCL_CHAN_ONE);
      ctrl.debug_pair_two = (cfg_ff[DCL_CHAN_LSB +: 2] == DCL_CHAN_TWO);
      ctrl.scan_port_enable = scan_rt_ff;
      ctrl.debugger_enable = ~dbg_view[1];
    end
  end

  assign flash_power_down = ctrl.flash_sleep_power_down & sleep_mode;

  // calibration window starts at its own offset, not on a 32-byte boundary
  assign adc_off = paddr - DCL_OFF_ADC0;
  assign adc_idx = adc_off[4:2];
  assign adc_hit = (paddr >= DCL_OFF_ADC0) && (adc_off[11:5] == 7'h00) &&
                   (adc_off[1:0] == 2'h0);

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (paddr == DCL_OFF_CFG0) begin
      nxt_prdata = {cfg_ff[31:2], dbg_view};
    end else if (paddr == DCL_OFF_RTCFG) begin
      nxt_prdata[DCL_RT_ECC_LSB +: 2] = ecc_rt_ff;
      nxt_prdata[DCL_RT_SCAN_BIT] = scan_rt_ff;
    end else if (paddr == DCL_OFF_STAT) begin
      nxt_prdata[0] = load_done;
      nxt_prdata[1] = code_protect;
    end else if (adc_hit) begin
      nxt_prdata = adc_ff[adc_idx];
    end
  end

  // read data registered in the setup cycle, valid in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= nxt_prdata;
    end
  end

  chk_ecc_copy: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_ff == DCL_ST_LOAD |=> ecc_rt_ff == $past(nv_cfg_word[9:8]))
    else $error("ecc copy not loaded");
  chk_ecc_locked: assert property (
    @(posedge pclk) disable iff (!presetn)
    load_done && !ecc_wr_ok |=> $stable(ecc_rt_ff))
    else $error("locked ecc field changed");
  chk_isa_pair: assert property (
    @(posedge pclk) disable iff (!presetn)
    load_done |-> ctrl.exception_isa_flag == (ctrl.core_isa == DCL_ISA_16))
    else $error("isa flag mismatch");
  chk_trace_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    load_done |-> ctrl.trace_feature_enable == cfg_ff[5])
    else $error("trace enable wrong");
  chk_chan_excl: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(ctrl.debug_pair_one && ctrl.debug_pair_two))
    else $error("both debug pairs selected");
  chk_scan_copy: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_ff == DCL_ST_LOAD |=> scan_rt_ff == $past(nv_cfg_word[2]))
    else $error("scan copy wrong");
  chk_dbg_protect: assert property (
    @(posedge pclk) disable iff (!presetn)
    load_done && code_protect |-> !ctrl.debugger_enable)
    else $error("debugger on under protection");
  chk_cfg_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    load_done ##1 load_done |-> $stable(cfg_ff))
    else $error("config word changed after load");
  chk_flash_sleep: assert property (
    @(posedge pclk) disable iff (!presetn)
    flash_power_down |-> sleep_mode && cfg_ff[10])
    else $error("flash down without cause");
  chk_adc_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr == DCL_OFF_ADC0 |=> prdata == adc_ff[0])
    else $error("calibration read wrong");

  cov_load: cover property (@(posedge pclk) state_ff == DCL_ST_LOAD);
  cov_ecc_write: cover property (
    @(posedge pclk) acc_wr && paddr == DCL_OFF_RTCFG && ecc_wr_ok);
  cov_protect: cover property (@(posedge pclk) load_done && code_protect);
  cov_sleep: cover property (@(posedge pclk) flash_power_down);
endmodule : dcl_loader
`default_nettype wire

/* File: tb/dcl_nv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcl_nv_model
  import dcl_pkg::*;
(
  input wire logic [11:0] cfg_low,
  output logic [31:0] nv_cfg_word,
  output logic [255:0] nv_adc_words
);
  // non-volatile store: word zero low bits from the bench
  assign nv_cfg_word = {20'h00000, cfg_low};
  // calibration data differs per word so a swapped index shows
  always_comb begin
    for (int g = 0; g < DCL_ADC_WORDS; g++) begin
      nv_adc_words[g*32+:32] = 32'hCA1B0000 + 32'(g);
    end
  end
endmodule : dcl_nv_model
`default_nettype wire

/* File: tb/device_config_word_loader_test.sv */
`timescale 1ns/1ps
`default_nettype none
module device_config_word_loader_test;
  import dcl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic code_protect = 1'b0;
  logic sleep_mode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [11:0] cfg_low = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, nv_cfg_word, q;
  logic [255:0] nv_adc_words;
  logic pready, pslverr, flash_power_down, load_done;
  dcl_ctrl_s ctrl;
  int fails = 0;
  int num_checks = 0;
  // rows: run-time byte, word zero low bits, expected ctrl
  logic [31:0] rows [4] = '{32'h387FCE5B, 32'h202924E4,
                            32'h181CF242, 32'h004A19F1};
  always #2.5 pclk = ~pclk;
  dcl_nv_model dcl_nv_model_i (.cfg_low(cfg_low),
    .nv_cfg_word(nv_cfg_word), .nv_adc_words(nv_adc_words));
  dcl_loader dcl_loader_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nv_cfg_word(nv_cfg_word), .nv_adc_words(nv_adc_words),
    .code_protect(code_protect), .sleep_mode(sleep_mode),
    .flash_power_down(flash_power_down), .ctrl(ctrl),
    .load_done(load_done));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      finish_test();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic do_reset();
    int n;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (load_done !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 10) begin
      fails++;
      finish_test();
    end
  endtask : do_reset
  initial begin
    for (int r = 0; r < 4; r++) begin
      cfg_low <= rows[r][23:12];
      sleep_mode <= 1'b0;
      do_reset();
      chk("ctrl", 32'(ctrl), 32'(rows[r][11:0]));
      chk("fpd off", 32'(flash_power_down), 32'h0);
      apb(1'b0, DCL_OFF_RTCFG, 32'h0, q);
      chk("rtcfg", q, {24'h0, rows[r][31:24]});
      sleep_mode <= 1'b1;
      cfg_low <= ~rows[r][23:12];
      @(posedge pclk);
      chk("fpd", 32'(flash_power_down), 32'(rows[r][22]));
      apb(1'b1, DCL_OFF_RTCFG, 32'h0, q);
      apb(1'b0, DCL_OFF_RTCFG, 32'h0, q);
      chk("ecc wr", q, {24'h0, rows[r][29:28] == 2'h3 ?
          rows[r][31:24] & 8'h0F : rows[r][31:24]});
      chk("hold", 32'(ctrl) & 32'h8FF, 32'(rows[r][11:0]) & 32'h8FF);
    end
    code_protect <= 1'b1;
    @(posedge pclk);
    chk("dbg en", 32'(ctrl.debugger_enable), 32'h0);
    apb(1'b0, DCL_OFF_CFG0, 32'h0, q);
    chk("dbg view", 32'(q[1:0]), 32'h3);
    // read back each calibration word; absent indices read zero
    for (int g = 0; g < 8; g++) begin
      apb(1'b0, DCL_OFF_ADC0 + 12'(4 * g), 32'h0, q);
      chk("adc", q, DCL_ADC_PRESENT[g] ? 32'hCA1B0000 + 32'(g) : 32'h0);
    end
    apb(1'b1, DCL_OFF_ADC0, 32'hFFFFFFFF, q);
    apb(1'b0, DCL_OFF_ADC0, 32'h0, q);
    chk("adc ro", q, 32'hCA1B0000);
    apb(1'b0, 12'h00C, 32'h0, q);
    chk("unmapped", q, 32'h0);
    apb(1'b0, DCL_OFF_STAT, 32'h0, q);
    chk("status", q, 32'h3);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    finish_test();
  end
endmodule : device_config_word_loader_test
`default_nettype wire
